// [rtl/qdac_ctrl.sv]
// Serial load control logic for a four-channel 14-bit converter
`timescale 1ns/1ps
module qdac_ctrl
  import qdac_pkg::*;
#(
  parameter int unsigned NCH = NUM_CHAN
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic load_strobe_n,
  input wire logic preset_n,
  input wire logic preset_level,
  output logic [CODE_BITS-1:0] input_code [NCH],
  output logic [CODE_BITS-1:0] dac_code [NCH],
  output logic load_pulse
);

  // Two-flop synchronisers for all pin inputs but core_clk, resetn and clk_en
  logic [1:0] sclk_s, sel_s, sdi_s, ld_s, pre_s, lvl_s;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclk_s <= SYNC_RESET;
      sel_s <= SYNC_SET;
      sdi_s <= SYNC_RESET;
      ld_s <= SYNC_SET;
      pre_s <= SYNC_SET;
      lvl_s <= SYNC_RESET;
    end else if (clk_en) begin
      sclk_s <= {sclk_s[0], serial_clk};
      sel_s <= {sel_s[0], select_n};
      sdi_s <= {sdi_s[0], serial_in};
      ld_s <= {ld_s[0], load_strobe_n};
      pre_s <= {pre_s[0], preset_n};
      lvl_s <= {lvl_s[0], preset_level};
    end
  end

  // Previous synchronised levels for edge detection
  logic sclk_d, sel_d;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
      sel_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d <= sclk_s[1];
      sel_d <= sel_s[1];
    end
  end

  logic sclk_rise, sel_rise, preset_act;
  logic [CODE_BITS-1:0] preset_code;
  assign sclk_rise = sclk_s[1] && !sclk_d && !sel_s[1];
  assign sel_rise = sel_s[1] && !sel_d;
  assign preset_act = !pre_s[1];
  assign preset_code = lvl_s[1] ? CODE_HALF : CODE_ZERO;

  // Shift register, MSB first; older surplus bits fall off the top
  logic [WORD_BITS-1:0] shift_reg;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shift_reg <= SHIFT_RESET;
    end else if (clk_en && sclk_rise) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], sdi_s[1]};
    end
  end

  // Address decode of the two top bits
  logic [1:0] chan_sel;
  logic chan_addr_hi, chan_addr_lo;
  logic [CODE_BITS-1:0] code_bits;
  assign chan_addr_hi = shift_reg[ADDR_HI_POS];
  assign chan_addr_lo = shift_reg[ADDR_LO_POS];
  assign chan_sel = {chan_addr_hi, chan_addr_lo};
  assign code_bits = shift_reg[CODE_BITS-1:0];

  // Internal load pulse registered for observation
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      load_pulse <= 1'b0;
    end else if (clk_en) begin
      load_pulse <= sel_rise && !preset_act;
    end
  end

  // Power-up window: preset is held until the level pin has crossed its
  // synchroniser, so the flop reset value never decides the power-up code
  logic [1:0] por_cnt;
  logic rst_done;
  assign rst_done = (por_cnt == POR_CYCLES);
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      por_cnt <= POR_RESET;
    end else if (clk_en && !rst_done) begin
      por_cnt <= por_cnt + 2'h1;
    end
  end

  // Per-channel input and output registers

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [CODE_BITS-1:0] next_in;
      always_comb begin
        next_in = input_code[g];
        if (!rst_done || preset_act) begin
          next_in = preset_code;
        end else if (sel_rise && (chan_sel == 2'(g))) begin
          next_in = code_bits;
        end
      end
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          input_code[g] <= CODE_ZERO;
        end else if (clk_en) begin
          input_code[g] <= next_in;
        end
      end
      // Output register: transparent while strobe is low, holds while high
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          dac_code[g] <= CODE_ZERO;
        end else if (clk_en) begin
          if (!rst_done || preset_act) begin
            dac_code[g] <= preset_code;
          end else if (!ld_s[1]) begin
            dac_code[g] <= input_code[g];
          end
        end
      end
    end
  endgenerate

  // Checks
  property p_shift;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && sclk_rise) |=> shift_reg[0] == $past(sdi_s[1]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit not taken");
  property p_hold;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && sel_s[1]) |=> $stable(shift_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("shift moved with select high");
  property p_load;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && rst_done && sel_rise && !preset_act && chan_sel == 2'h2)
      |=> input_code[2] == $past(code_bits);
  endproperty
  a_load: assert property (p_load) else $error("addressed channel not loaded");
  property p_noload;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && rst_done && sel_rise && !preset_act && chan_sel != 2'h0)
      |=> $stable(input_code[0]);
  endproperty
  a_noload: assert property (p_noload) else $error("wrong channel loaded");
  property p_transp;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && rst_done && !preset_act && !ld_s[1]) |=> dac_code[1] == $past(input_code[1]);
  endproperty
  a_transp: assert property (p_transp) else $error("output not transparent");
  property p_latch;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && rst_done && !preset_act && ld_s[1]) |=> $stable(dac_code[3]);
  endproperty
  a_latch: assert property (p_latch) else $error("output not held");
  property p_zero;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && preset_act && !lvl_s[1])
      |=> input_code[0] == CODE_ZERO && dac_code[0] == CODE_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("zero preset failed");
  property p_half;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && preset_act && lvl_s[1]) |=> input_code[3] == CODE_HALF && dac_code[3] == CODE_HALF;
  endproperty
  a_half: assert property (p_half) else $error("half preset failed");
  property p_por;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && !rst_done) |=> dac_code[2] == $past(preset_code);
  endproperty
  a_por: assert property (p_por) else $error("reset code wrong");
  property p_load_b;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && rst_done && sel_rise && !preset_act && chan_sel == 2'h1)
      |=> input_code[1] == $past(code_bits);
  endproperty
  a_load_b: assert property (p_load_b) else $error("second channel not loaded");
  property p_pulse;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && load_pulse) |=> !load_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
  property p_pre_wins;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && preset_act) |=> !load_pulse;
  endproperty
  a_pre_wins: assert property (p_pre_wins) else $error("load during preset");
  property p_surplus;
    @(posedge core_clk) disable iff (!resetn)
      (clk_en && sclk_rise) |=> shift_reg[WORD_BITS-1:1] == $past(shift_reg[WORD_BITS-2:0]);
  endproperty
  a_surplus: assert property (p_surplus) else $error("older bits not pushed out");
  // Zero-code preset seen at least once
  c_zero: cover property (@(posedge core_clk) disable iff (!resetn) preset_act && !lvl_s[1]);
  c_load: cover property (@(posedge core_clk) disable iff (!resetn) load_pulse);
  c_preset: cover property (@(posedge core_clk) disable iff (!resetn) preset_act && lvl_s[1]);
  c_transp: cover property (@(posedge core_clk) disable iff (!resetn) !ld_s[1] && rst_done);

endmodule

// [inc/qdac_pkg.sv]
// Package holding constants for the quad converter serial load control block
package qdac_pkg;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CODE_BITS = 14;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned ADDR_HI_POS = 15;
  localparam int unsigned ADDR_LO_POS = 14;
  localparam logic [13:0] CODE_ZERO = 14'h0000;
  localparam logic [13:0] CODE_HALF = 14'h2000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [1:0] SYNC_SET = 2'h3;
  localparam logic [1:0] POR_RESET = 2'h0;
  localparam logic [1:0] POR_CYCLES = 2'h3;
endpackage

// [tb/qdac_host.sv]
// Host model that frames bytes onto the serial link
`timescale 1ns/1ps
module qdac_host (
  input wire logic core_clk,
  output logic serial_clk,
  output logic select_n,
  output logic serial_in
);
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Select stays low from open to close so both bytes land in one word
  task automatic open();
    select_n <= 1'b0;
  endtask
  // MSB first, data set with the link clock low, clock idles low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge core_clk);
      serial_in <= b[i];
      serial_clk <= 1'b0;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    serial_clk <= 1'b0;
  endtask
  // Released data line shows the inverse of its last bit
  task automatic close();
    repeat (4) @(posedge core_clk);
    select_n <= 1'b1;
    serial_in <= ~serial_in;
  endtask
endmodule

// [tb/qdac_ctrl_bench.sv]
// Self-checking bench for the quad converter serial load control
`timescale 1ns/1ps
module qdac_ctrl_bench;
  import qdac_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic load_strobe_n = 1'b1;
  logic preset_n = 1'b1;
  logic preset_level = 1'b1;
  logic serial_clk;
  logic select_n;
  logic serial_in;
  logic load_pulse;
  logic [CODE_BITS-1:0] input_code [NUM_CHAN];
  logic [CODE_BITS-1:0] dac_code [NUM_CHAN];
  logic [CODE_BITS-1:0] exp_code [NUM_CHAN];
  int n_fail = 0;
  int comparisons = 0;
  always #20 core_clk = ~core_clk;
  qdac_ctrl u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .serial_clk(serial_clk), .select_n(select_n), .serial_in(serial_in),
    .load_strobe_n(load_strobe_n), .preset_n(preset_n), .preset_level(preset_level),
    .input_code(input_code), .dac_code(dac_code), .load_pulse(load_pulse));
  qdac_host u_host (.core_clk(core_clk), .serial_clk(serial_clk), .select_n(select_n),
    .serial_in(serial_in));
  // Compare one code
  task automatic check(input logic [13:0] seen, input logic [13:0] expv);
    comparisons++;
    if (seen !== expv) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  // Counts and verdict
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One word as two bytes, optionally after a surplus byte; bounded wait for the load
  task automatic load(input logic [1:0] ch, input logic [13:0] code, input logic extra);
    int k;
    @(posedge core_clk);
    u_host.open();
    if (extra) begin
      u_host.send_byte(8'ha5);
    end
    u_host.send_byte({ch, code[13:8]});
    u_host.send_byte(code[7:0]);
    u_host.close();
    for (k = 0; k < 20 && load_pulse !== 1'b1; k++) @(negedge core_clk);
    if (k == 20) begin
      n_fail++;
      final_report();
    end
    @(negedge core_clk);
    check(14'(load_pulse), 14'h0000);
  endtask
  // Check every channel against one code
  task automatic check_all(input logic [13:0] e);
    for (int c = 0; c < NUM_CHAN; c++) begin
      check(input_code[c], e);
      check(dac_code[c], e);
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    check_all(CODE_HALF);
    $display("power-up preset test done");
    for (int c = 0; c < NUM_CHAN; c++) begin
      exp_code[c] = 14'h1c00 + 14'(c * 855);
      load(2'(c), exp_code[c], c == 3);
      check(input_code[c], exp_code[c]);
      check(dac_code[c], CODE_HALF);
    end
    $display("serial load test done");
    @(posedge core_clk);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    for (int c = 0; c < NUM_CHAN; c++) check(dac_code[c], exp_code[c]);
    @(posedge core_clk);
    load_strobe_n <= 1'b1;
    load(2'h1, 14'h3fff, 1'b0);
    check(input_code[1], 14'h3fff);
    check(dac_code[1], exp_code[1]);
    exp_code[1] = 14'h3fff;
    @(posedge core_clk);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check(dac_code[1], exp_code[1]);
    @(posedge core_clk);
    load_strobe_n <= 1'b1;
    $display("strobe test done");
    preset_level <= 1'b0;
    preset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check_all(CODE_ZERO);
    @(posedge core_clk);
    preset_level <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check_all(CODE_HALF);
    @(posedge core_clk);
    preset_n <= 1'b1;
    $display("preset test done");
    final_report();
  end
endmodule
